/* logic/mcd_pkg.sv */
package mcd_pkg;
  // register addresses (24-bit map); those from 0x280 up also answer at +0x100, the 0x10x ones do not
  localparam logic [9:0] ADDR_PHASE_A      = 10'h108;
  localparam logic [9:0] ADDR_PHASE_B      = 10'h109;
  localparam logic [9:0] ADDR_PERIOD       = 10'h10e;
  localparam logic [9:0] ADDR_IGAIN_A      = 10'h280;
  localparam logic [9:0] ADDR_VGAIN_1      = 10'h281;
  localparam logic [9:0] ADDR_WGAIN_A      = 10'h282;
  localparam logic [9:0] ADDR_VARGAIN_A    = 10'h283;
  localparam logic [9:0] ADDR_VAGAIN_A     = 10'h284;
  localparam logic [9:0] ADDR_IRMSOS_A     = 10'h286;
  localparam logic [9:0] ADDR_VOLTAGE_RMS_OFFSET       = 10'h288;
  localparam logic [9:0] ADDR_WOS_A        = 10'h289;
  localparam logic [9:0] ADDR_VAROS_A      = 10'h28a;
  localparam logic [9:0] ADDR_VAOS_A       = 10'h28b;
  localparam logic [9:0] ADDR_IGAIN_B      = 10'h28c;
  localparam logic [9:0] ADDR_VGAIN_2      = 10'h28d;
  localparam logic [9:0] ADDR_WGAIN_B      = 10'h28e;
  localparam logic [9:0] ADDR_VARGAIN_B    = 10'h28f;
  localparam logic [9:0] ADDR_VAGAIN_B     = 10'h290;
  localparam logic [9:0] ADDR_IRMSOS_B     = 10'h292;
  localparam logic [9:0] ADDR_WOS_B        = 10'h295;
  localparam logic [9:0] ADDR_VAROS_B      = 10'h296;
  localparam logic [9:0] ADDR_VAOS_B       = 10'h297;
  localparam logic [9:0] ADDR_ALIAS        = 10'h100;

  // reset values and scaling
  localparam logic [23:0] GAIN_UNITY       = 24'h400000;
  localparam logic [23:0] OFFSET_RESET     = 24'h000000;
  localparam logic [9:0]  PHASE_RESET      = 10'h000;
  localparam int          GAIN_FRAC_BITS   = 22;
  localparam int          POWER_OS_SHIFT   = 9;
  localparam int          RMS_OS_SHIFT     = 12;

  // clocking: core 125 MHz, phase step 1.117 us, period tick 4.48 us
  localparam int          CORE_CLK_KHZ     = 125000;
  localparam int          PHASE_STEP_NS    = 1117;
  localparam int          PERIOD_TICK_NS   = 4480;
  localparam int          PHASE_STEP_CYC   = (PHASE_STEP_NS * CORE_CLK_KHZ) / 1000000;
  localparam int          PERIOD_TICK_CYC  = (PERIOD_TICK_NS * CORE_CLK_KHZ) / 1000000;
  localparam int          PHASE_MAG_MAX    = 383;
  localparam int          DELAY_DEPTH      = 2 * PHASE_MAG_MAX + 1;

  // one raw sample set from the metering core
  typedef struct packed {
    logic signed [23:0] powerW;
    logic signed [23:0] powerVar;
    logic signed [23:0] powerVa;
    logic [47:0]        msqI;
  } mcd_chan_raw_t;

  typedef struct packed {
    logic signed [23:0] powerW;
    logic signed [23:0] powerVar;
    logic signed [23:0] powerVa;
    logic [23:0]        rmsI;
  } mcd_chan_cal_t;

  typedef struct packed {
    logic [23:0] wGain;
    logic [23:0] varGain;
    logic [23:0] vaGain;
    logic [23:0] wOs;
    logic [23:0] varOs;
    logic [23:0] vaOs;
    logic [23:0] rmsOs;
  } mcd_chan_cfg_t;
endpackage

/* logic/mcd_meter_cal.sv */
`timescale 1ns/1ps
// Overview of operation
// - active power times active gain over 0x400000; unity at reset
// - reactive and apparent power scaled by own per-channel gains likewise
// - channel B current gain scales channel B current path
// - channel A current gain scales channel A current path the same way
// - only first voltage gain affects voltage rms
// - phase register is 10-bit sign-magnitude; msb 0 delays, 1 advances
// - each phase step shifts current path by 139 master clocks (PHASE_STEP_CYC, about 1.117 us)
// - active offsets signed 24-bit, reset zero, added shifted by nine bits
// - reactive offsets added like active offsets
// - apparent offsets added like active offsets
// - voltage rms offset times 2^12 added before square root
// - current rms offsets applied before square root like voltage
// - line period measured into 16-bit read-only register every period
// - period result settles within 30 to 40 ms
// - period counts 223 kHz ticks; period is value plus one over rate
// - steady line gives period results within 1 LSB
module mcd_meter_cal
  import mcd_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  input  wire logic [9:0]          regAddr,
  input  wire logic [23:0]         regWdata,
  output logic [23:0]              regRdata,
  output logic                     regAck,
  input  wire logic                sampleValid,
  input  wire logic signed [23:0]  currentA,
  input  wire logic signed [23:0]  currentB,
  input  wire logic [47:0]         msqV,
  input  wire mcd_chan_raw_t       rawA,
  input  wire mcd_chan_raw_t       rawB,
  input  wire logic                zeroCross,
  output logic signed [23:0]       currentAOut,
  output logic signed [23:0]       currentBOut,
  output mcd_chan_cal_t            calA,
  output mcd_chan_cal_t            calB,
  output logic [23:0]              voltageRms,
  output logic                     calValid
);

  // configuration registers
  logic [9:0]    phaseA_r;
  logic [9:0]    phaseB_r;
  logic [23:0]   iGainA_r;
  logic [23:0]   iGainB_r;
  logic [23:0]   vGain1_r;
  logic [23:0]   vGain2_r;
  logic [23:0]   voltage_rms_offset_r;
  mcd_chan_cfg_t cfgA_r;
  mcd_chan_cfg_t cfgB_r;
  logic [15:0]   period_r;

  // alias folding: both maps land on the same register
  logic [9:0] addrFold;
  assign addrFold = (regAddr >= (ADDR_ALIAS + 10'h200)) ? regAddr - ADDR_ALIAS : regAddr;

  // register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseA_r <= PHASE_RESET;
      phaseB_r <= PHASE_RESET;
      iGainA_r <= GAIN_UNITY;
      iGainB_r <= GAIN_UNITY;
      vGain1_r <= GAIN_UNITY;
      vGain2_r <= GAIN_UNITY;
      voltage_rms_offset_r <= OFFSET_RESET;
      cfgA_r   <= '{GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, OFFSET_RESET,
                    OFFSET_RESET, OFFSET_RESET, OFFSET_RESET};
      cfgB_r   <= '{GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, OFFSET_RESET,
                    OFFSET_RESET, OFFSET_RESET, OFFSET_RESET};
    end else if (regWrite) begin
      unique case (addrFold)
        ADDR_PHASE_A:   phaseA_r       <= regWdata[9:0];
        ADDR_PHASE_B:   phaseB_r       <= regWdata[9:0];
        ADDR_IGAIN_A:   iGainA_r       <= regWdata;
        ADDR_IGAIN_B:   iGainB_r       <= regWdata;
        ADDR_VGAIN_1:   vGain1_r       <= regWdata;
        ADDR_VGAIN_2:   vGain2_r       <= regWdata;
        ADDR_VOLTAGE_RMS_OFFSET:    voltage_rms_offset_r       <= regWdata;
        ADDR_WGAIN_A:   cfgA_r.wGain   <= regWdata;
        ADDR_VARGAIN_A: cfgA_r.varGain <= regWdata;
        ADDR_VAGAIN_A:  cfgA_r.vaGain  <= regWdata;
        ADDR_WOS_A:     cfgA_r.wOs     <= regWdata;
        ADDR_VAROS_A:   cfgA_r.varOs   <= regWdata;
        ADDR_VAOS_A:    cfgA_r.vaOs    <= regWdata;
        ADDR_IRMSOS_A:  cfgA_r.rmsOs   <= regWdata;
        ADDR_WGAIN_B:   cfgB_r.wGain   <= regWdata;
        ADDR_VARGAIN_B: cfgB_r.varGain <= regWdata;
        ADDR_VAGAIN_B:  cfgB_r.vaGain  <= regWdata;
        ADDR_WOS_B:     cfgB_r.wOs     <= regWdata;
        ADDR_VAROS_B:   cfgB_r.varOs   <= regWdata;
        ADDR_VAOS_B:    cfgB_r.vaOs    <= regWdata;
        ADDR_IRMSOS_B:  cfgB_r.rmsOs   <= regWdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  logic [23:0] rdMux;
  always_comb begin
    unique case (addrFold)
      ADDR_PHASE_A:   rdMux = {14'h0, phaseA_r};
      ADDR_PHASE_B:   rdMux = {14'h0, phaseB_r};
      ADDR_PERIOD:    rdMux = {8'h0, period_r};
      ADDR_IGAIN_A:   rdMux = iGainA_r;
      ADDR_IGAIN_B:   rdMux = iGainB_r;
      ADDR_VGAIN_1:   rdMux = vGain1_r;
      ADDR_VGAIN_2:   rdMux = vGain2_r;
      ADDR_VOLTAGE_RMS_OFFSET:    rdMux = voltage_rms_offset_r;
      ADDR_WGAIN_A:   rdMux = cfgA_r.wGain;
      ADDR_VARGAIN_A: rdMux = cfgA_r.varGain;
      ADDR_VAGAIN_A:  rdMux = cfgA_r.vaGain;
      ADDR_WOS_A:     rdMux = cfgA_r.wOs;
      ADDR_VAROS_A:   rdMux = cfgA_r.varOs;
      ADDR_VAOS_A:    rdMux = cfgA_r.vaOs;
      ADDR_IRMSOS_A:  rdMux = cfgA_r.rmsOs;
      ADDR_WGAIN_B:   rdMux = cfgB_r.wGain;
      ADDR_VARGAIN_B: rdMux = cfgB_r.varGain;
      ADDR_VAGAIN_B:  rdMux = cfgB_r.vaGain;
      ADDR_WOS_B:     rdMux = cfgB_r.wOs;
      ADDR_VAROS_B:   rdMux = cfgB_r.varOs;
      ADDR_VAOS_B:    rdMux = cfgB_r.vaOs;
      ADDR_IRMSOS_B:  rdMux = cfgB_r.rmsOs;
      default:        rdMux = 24'h000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 24'h000000;
      regAck   <= 1'b0;
    end else begin
      regRdata <= regRead ? rdMux : regRdata;
      regAck   <= regRead | regWrite;
    end
  end

  // gain helper: value * gain / 2^22, saturated to 24 bits signed
  function automatic logic signed [23:0] applyGain(input logic signed [23:0] v,
                                                   input logic [23:0] g);
    logic signed [48:0] prod;
    logic signed [26:0] scaled;
    prod   = v * $signed({1'b0, g});
    scaled = 27'(prod >>> GAIN_FRAC_BITS);
    if (scaled > 27'sh7fffff)       applyGain = 24'sh7fffff;
    else if (scaled < -27'sh800000) applyGain = 24'sh800000;
    else                            applyGain = scaled[23:0];
  endfunction

  // power offset helper: offset carries nine fractional bits
  function automatic logic signed [23:0] addPowOs(input logic signed [23:0] v,
                                                  input logic [23:0] os);
    logic signed [33:0] sum;
    sum      = ($signed({{1{v[23]}}, v, 9'h000}) + $signed({{10{os[23]}}, os}))
               >>> POWER_OS_SHIFT;
    addPowOs = sum[23:0];
  endfunction

  // integer square root of the offset-corrected mean square
  function automatic logic [23:0] rmsCorr(input logic [47:0] msq,
                                          input logic [23:0] os);
    logic signed [49:0] sq;
    logic [47:0]        rem;
    logic [23:0]        root;
    logic [47:0]        trial;
    sq   = $signed({2'b00, msq}) + $signed({{14{os[23]}}, os, 12'h000});
    rem  = sq[49] ? 48'h0 : sq[47:0];
    root = 24'h000000;
    for (int b = 23; b >= 0; b--) begin
      trial = 48'({root | (24'h1 << b)}) * 48'({root | (24'h1 << b)});
      if (trial <= rem) root = root | (24'h1 << b);
    end
    rmsCorr = root;
  endfunction

  // voltage rms: mean square scaled by first voltage gain only
  logic [47:0] msqVGain;
  logic [95:0] msqVProd;
  assign msqVProd = msqV * (48'(vGain1_r) * 48'(vGain1_r)) >> (2 * GAIN_FRAC_BITS);
  assign msqVGain = msqVProd[47:0];

  // current mean square scaled by the square of each current gain
  logic [47:0] msqIA;
  logic [47:0] msqIB;
  logic [95:0] msqIAProd;
  logic [95:0] msqIBProd;
  assign msqIAProd = rawA.msqI * (48'(iGainA_r) * 48'(iGainA_r)) >> (2 * GAIN_FRAC_BITS);
  assign msqIBProd = rawB.msqI * (48'(iGainB_r) * 48'(iGainB_r)) >> (2 * GAIN_FRAC_BITS);
  assign msqIA = msqIAProd[47:0];
  assign msqIB = msqIBProd[47:0];

  // calibrated channel sets from current registers
  mcd_chan_cal_t calANxt;
  mcd_chan_cal_t calBNxt;
  assign calANxt.powerW   = addPowOs(applyGain(rawA.powerW, cfgA_r.wGain), cfgA_r.wOs);
  assign calANxt.powerVar = addPowOs(applyGain(rawA.powerVar, cfgA_r.varGain), cfgA_r.varOs);
  assign calANxt.powerVa  = addPowOs(applyGain(rawA.powerVa, cfgA_r.vaGain), cfgA_r.vaOs);
  assign calANxt.rmsI     = rmsCorr(msqIA, cfgA_r.rmsOs);
  assign calBNxt.powerW   = addPowOs(applyGain(rawB.powerW, cfgB_r.wGain), cfgB_r.wOs);
  assign calBNxt.powerVar = addPowOs(applyGain(rawB.powerVar, cfgB_r.varGain), cfgB_r.varOs);
  assign calBNxt.powerVa  = addPowOs(applyGain(rawB.powerVa, cfgB_r.vaGain), cfgB_r.vaOs);
  assign calBNxt.rmsI     = rmsCorr(msqIB, cfgB_r.rmsOs);

  // result registers, refreshed on each raw sample
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      calA       <= '0;
      calB       <= '0;
      voltageRms <= 24'h000000;
      calValid   <= 1'b0;
    end else begin
      calValid <= sampleValid;
      if (sampleValid) begin
        calA       <= calANxt;
        calB       <= calBNxt;
        voltageRms <= rmsCorr(msqVGain, voltage_rms_offset_r);
      end
    end
  end

  // phase step tick: master clock over PHASE_STEP_CYC (139)
  logic [7:0] phTickCnt_r;
  logic       phTick;
  assign phTick = (phTickCnt_r == 8'(PHASE_STEP_CYC - 1));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) phTickCnt_r <= 8'h00;
    else        phTickCnt_r <= phTick ? 8'h00 : phTickCnt_r + 8'h01;
  end

  // current delay lines; nominal tap is mid-depth so advance is a shorter delay
  logic signed [23:0] dlyA [DELAY_DEPTH];
  logic signed [23:0] dlyB [DELAY_DEPTH];
  always_ff @(posedge core_clk) begin
    if (phTick) begin
      dlyA[0] <= applyGain(currentA, iGainA_r);
      dlyB[0] <= applyGain(currentB, iGainB_r);
      for (int i = 1; i < DELAY_DEPTH; i++) begin
        dlyA[i] <= dlyA[i-1];
        dlyB[i] <= dlyB[i-1];
      end
    end
  end

  // tap select from sign-magnitude phase value
  logic [9:0] tapA;
  logic [9:0] tapB;
  assign tapA = phaseA_r[9] ? 10'(PHASE_MAG_MAX) - {1'b0, phaseA_r[8:0]}
                            : 10'(PHASE_MAG_MAX) + {1'b0, phaseA_r[8:0]};
  assign tapB = phaseB_r[9] ? 10'(PHASE_MAG_MAX) - {1'b0, phaseB_r[8:0]}
                            : 10'(PHASE_MAG_MAX) + {1'b0, phaseB_r[8:0]};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      currentAOut <= 24'sh000000;
      currentBOut <= 24'sh000000;
    end else begin
      currentAOut <= dlyA[tapA];
      currentBOut <= dlyB[tapB];
    end
  end

  // zero-crossing input synchroniser
  logic zxMeta_r;
  logic zxSync_r;
  logic zxPrev_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      zxMeta_r <= 1'b0;
      zxSync_r <= 1'b0;
      zxPrev_r <= 1'b0;
    end else begin
      zxMeta_r <= zeroCross;
      zxSync_r <= zxMeta_r;
      zxPrev_r <= zxSync_r;
    end
  end

  // period tick and counter, rising crossing to rising crossing
  logic [9:0]  prTickCnt_r;
  logic [15:0] perCnt_r;
  logic        prTick;
  logic        zxRise;
  assign prTick = (prTickCnt_r == 10'(PERIOD_TICK_CYC - 1));
  assign zxRise = zxSync_r & ~zxPrev_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prTickCnt_r <= 10'h000;
      perCnt_r    <= 16'h0000;
      period_r    <= 16'h0000;
    end else begin
      prTickCnt_r <= prTick ? 10'h000 : prTickCnt_r + 10'h001;
      if (zxRise) begin
        // register holds tick count minus one, so period is value plus one
        period_r <= (perCnt_r == 16'h0000) ? 16'h0000
                                           : perCnt_r - 16'h0001;
        perCnt_r <= 16'h0000;
      end else if (prTick && perCnt_r != 16'hffff) begin
        perCnt_r <= perCnt_r + 16'h0001;
      end
    end
  end

endmodule

/* verification/mcd_meter_cal_properties.sv */
`timescale 1ns/1ps
module mcd_meter_cal_properties
  import mcd_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [9:0]    regAddr,
  input  wire logic [23:0]   regRdata,
  input  wire logic          regAck,
  input  wire logic          sampleValid,
  input  wire mcd_chan_cal_t calA,
  input  wire mcd_chan_cal_t calB,
  input  wire logic [23:0]   voltageRms,
  input  wire logic          calValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // bus answers exactly one cycle after each request, never otherwise
  AST_ACK_FOLLOWS_REQ: assert property ((regWrite || regRead) |=> regAck)
    else $error("ack missing one cycle after request");
  AST_ACK_NEEDS_REQ: assert property (regAck |-> $past(regWrite || regRead))
    else $error("ack without a request");
  // results appear one cycle after a sample and hold in between
  AST_CAL_FOLLOWS_SAMPLE: assert property (sampleValid |=> calValid)
    else $error("result strobe missing after sample");
  AST_CAL_NEEDS_SAMPLE: assert property (calValid |-> $past(sampleValid))
    else $error("result strobe without sample");
  AST_RESULTS_HOLD: assert property (!sampleValid |=>
    $stable(calA) && $stable(calB) && $stable(voltageRms))
    else $error("results changed without sample");
  // read data holds and narrow registers read zero above their width
  AST_RDATA_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without read");
  AST_PERIOD_WIDTH: assert property (regRead && regAddr == ADDR_PERIOD |=>
    regRdata[23:16] == 8'h00)
    else $error("period read wider than 16 bits");
  AST_PHASE_WIDTH: assert property (regRead &&
    (regAddr == ADDR_PHASE_A || regAddr == ADDR_PHASE_B) |=> regRdata[23:10] == 14'h0)
    else $error("phase read wider than 10 bits");
  AST_UNMAPPED_ZERO: assert property (regRead && regAddr == 10'h000 |=> regRdata == 24'h0)
    else $error("unmapped read not zero");
endmodule

bind mcd_meter_cal mcd_meter_cal_properties u_props (
  .core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regRdata(regRdata), .regAck(regAck), .sampleValid(sampleValid),
  .calA(calA), .calB(calB), .voltageRms(voltageRms), .calValid(calValid)
);

/* verification/mcd_meter_cal_test.sv */
`timescale 1ns/1ps
module mcd_meter_cal_test
  import mcd_pkg::*;
;
  localparam logic [23:0] PER_EXP = 24'(5600 / PERIOD_TICK_CYC - 1);
  logic                 core_clk    = 1'b0;
  logic                 rst_b       = 1'b0;
  logic                 regWrite    = 1'b0;
  logic                 regRead     = 1'b0;
  logic                 sampleValid = 1'b0;
  logic                 zeroCross   = 1'b0;
  logic [9:0]           regAddr     = '0;
  logic [23:0]          regWdata    = '0;
  logic signed [23:0]   currentA    = '0;
  logic signed [23:0]   currentB    = '0;
  logic [47:0]          msqV        = '0;
  mcd_chan_raw_t        rawA        = '0;
  mcd_chan_raw_t        rawB        = '0;
  logic [23:0]          regRdata;
  logic                 regAck;
  logic                 calValid;
  logic signed [23:0]   currentAOut;
  logic signed [23:0]   currentBOut;
  mcd_chan_cal_t        calA;
  mcd_chan_cal_t        calB;
  logic [23:0]          voltageRms;
  logic [23:0]          p1;
  logic [23:0]          p2;
  int                   mismatches   = 0;
  int                   total_checks = 0;

  always #4 core_clk = ~core_clk;

  mcd_meter_cal uut (
    .core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .sampleValid(sampleValid), .currentA(currentA), .currentB(currentB), .msqV(msqV),
    .rawA(rawA), .rawB(rawB), .zeroCross(zeroCross), .currentAOut(currentAOut),
    .currentBOut(currentBOut), .calA(calA), .calB(calB), .voltageRms(voltageRms),
    .calValid(calValid)
  );

  // verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle bus strobes, answer looked at in the ack cycle
  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    @(negedge core_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
    chk({23'h0, regAck}, 24'h1);
  endtask

  task automatic rdv(input logic [9:0] a, output logic [23:0] v);
    @(negedge core_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRead = 1'b0;
    chk({23'h0, regAck}, 24'h1);
    v = regRdata;
  endtask

  task automatic rd(input logic [9:0] a, input logic [23:0] e);
    logic [23:0] v;
    rdv(a, v);
    chk(v, e);
  endtask

  task automatic smp();
    @(negedge core_clk);
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
    chk({23'h0, calValid}, 24'h1);
  endtask

  // one line cycle of 5600 core cycles
  task automatic zx();
    @(negedge core_clk);
    zeroCross = 1'b1;
    repeat (2799) @(negedge core_clk);
    zeroCross = 1'b0;
    repeat (2800) @(negedge core_clk);
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    rd(ADDR_WGAIN_A, GAIN_UNITY);
    rd(ADDR_WGAIN_B + ADDR_ALIAS, GAIN_UNITY);
    rd(ADDR_WOS_B, OFFSET_RESET);
    rd(ADDR_VOLTAGE_RMS_OFFSET, OFFSET_RESET);
    rd(10'h000, 24'h0);
    wr(ADDR_PHASE_A, 24'hffff7f);
    rd(ADDR_PHASE_A, 24'h00037f);
    wr(ADDR_PHASE_B, 24'h00017f);
    rd(ADDR_PHASE_B, 24'h00017f);
    wr(ADDR_WGAIN_A + ADDR_ALIAS, 24'h600000);
    wr(ADDR_VARGAIN_A, 24'h200000);
    wr(ADDR_VAGAIN_B, 24'h600000);
    wr(ADDR_WOS_B, 24'h000400);
    wr(ADDR_VAROS_A, 24'hfffc00);
    wr(ADDR_VAOS_A, 24'h000200);
    wr(ADDR_IGAIN_A, 24'h200000);
    wr(ADDR_IGAIN_B, 24'h800000);
    wr(ADDR_IRMSOS_B, 24'h000029);
    wr(ADDR_VGAIN_1, 24'h800000);
    wr(ADDR_VGAIN_2, 24'h200000);
    // full advance on both channels selects the shortest tap
    wr(ADDR_PHASE_B, 24'h00037f);
    currentA = 24'sh001000;
    currentB = 24'sh001000;
    repeat (300) @(negedge core_clk);
    chk(currentAOut, 24'h000800);
    chk(currentBOut, 24'h002000);
    rawA = {24'h001000, 24'h001000, 24'h001000, 48'd1000000};
    rawB = {24'h001000, 24'h001000, 24'h001000, 48'd409600};
    msqV = 48'd1000000;
    smp();
    chk(calA.powerW, 24'h001800);
    chk(calA.powerVar, 24'h0007fe);
    chk(calA.powerVa, 24'h001001);
    chk(calB.powerW, 24'h001002);
    chk(calB.powerVar, 24'h001000);
    chk(calB.powerVa, 24'h001800);
    chk(calA.rmsI, 24'h0001f4);
    chk(calB.rmsI, 24'h000540);
    chk(voltageRms, 24'h0007d0);
    // second voltage gain must leave the rms alone
    wr(ADDR_VGAIN_2, 24'h600000);
    rd(ADDR_VGAIN_2 + ADDR_ALIAS, 24'h600000);
    smp();
    chk(voltageRms, 24'h0007d0);
    wr(ADDR_VOLTAGE_RMS_OFFSET, 24'hfff000);
    smp();
    chk(voltageRms, 24'h000000);
    // period register is read-only and tracks the line
    wr(ADDR_PERIOD, 24'h001234);
    rd(ADDR_PERIOD, 24'h000000);
    repeat (3) zx();
    rdv(ADDR_PERIOD, p1);
    zx();
    rdv(ADDR_PERIOD, p2);
    chk({23'h0, p1 + 24'h1 >= PER_EXP && p1 <= PER_EXP + 24'h1}, 24'h1);
    chk({23'h0, p2 + 24'h1 >= p1 && p2 <= p1 + 24'h1}, 24'h1);
    stop_test();
  end
endmodule
